// *** verilog/csqm_pkg.sv ***
// Constants and types shared by the CAN signal quality monitor
package csqm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int D_W = 13;
  localparam int SMP_PER_BIT = 64;
  localparam logic [5:0] SMP_LAST = 6'h3f;
  localparam logic [5:0] EVAL_FIRST = 6'h0a;
  localparam logic [5:0] EVAL_LAST = 6'h35;
  localparam logic [5:0] REF_POS = 6'h2a;
  localparam logic [6:0] EDGE_SAT = 7'h40;
  localparam logic [6:0] EDGE_ZERO = 7'h20;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam int LO_NUM = 26;
  localparam int HI_NUM = 230;
  localparam int THR_SHIFT = 8;
  localparam int V_LO_MV = 1000;
  localparam int V_HI_MV = 2200;
  localparam int IDLE_MAX_MV = 500;
  localparam int FAULT_MIN_MV = 900;
  localparam int WIN_S = 1;
  localparam int unsigned WIN_CYC = CLK_HZ * WIN_S;
  localparam int FACT_S = 10;
  localparam int unsigned FACT_CYC = CLK_HZ * FACT_S;
  localparam logic [1:0] BUS_INVALID = 2'h0;
  localparam logic [1:0] BUS_IDLE = 2'h1;
  localparam logic [1:0] BUS_FAULT = 2'h2;
  localparam logic [1:0] BUS_ACTIVE = 2'h3;
  localparam int FLG_QUAL = 0;
  localparam int FLG_SPAN = 1;
  localparam int FLG_RISE = 2;
  localparam int FLG_FALL = 3;
  typedef enum logic [1:0] {
    CSQM_MON_IDLE = 2'b01,
    CSQM_MON_RUN = 2'b10
  } csqm_mon_t;
endpackage

// *** verilog/csqm_monitor.sv ***
// CAN signal quality monitor: sampling, edges, quality, bus condition
//
// Summary of operation
// - Take 64 samples per configured bit time
// - Evaluate clean span over 44 positions
// - Skip first and last ten sample positions
// - Sub-sample dips may go unseen
// - No measuring during arbitration and acknowledge
// - Time edges between 10% and 90%
// - Edge reference is level at sample 42
// - Edge times in 1/64 bit, 0..64
// - Keep slowest rise and fall per frame
// - Edge score (32-x)/32, x clipped 32
// - Span score linear 1.0 V to 2.2 V
// - Reflection score two minus pp/span ratio
// - Quality is mean of three scores
// - Quality confined to 0..100 percent
// - One-second window detects level changes
// - Static bus: check idle differential level
// - Bus load each second from baud
// - Keep minimum and maximum bus load
// - Bus condition runs regardless of monitoring
// - Ten-second button press restores defaults
// - Flags assignable to isolated error output
// - Static: idle below 0.5, fault above 0.9
// - Live and sticky flag per error
`timescale 1ns/100ps
module csqm_monitor #(
  parameter int unsigned WIN_CYC = csqm_pkg::WIN_CYC,
  parameter int unsigned FACT_CYC = csqm_pkg::FACT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] baud_div_i,
  input wire logic signed [csqm_pkg::D_W-1:0] diff_mv_i,
  input wire logic rx_i,
  input wire logic bit_start_i,
  input wire logic frame_active_i,
  input wire logic arb_ack_phase_i,
  input wire logic start_stop_i,
  input wire logic factory_btn_i,
  input wire logic [6:0] quality_limit_i,
  input wire logic [csqm_pkg::D_W-1:0] span_limit_mv_i,
  input wire logic [6:0] edge_limit_i,
  input wire logic [7:0] err_assign_i,
  output logic monitoring_o,
  output logic result_valid_o,
  output logic [6:0] quality_o,
  output logic signed [csqm_pkg::D_W-1:0] span_mv_o,
  output logic signed [csqm_pkg::D_W-1:0] pp_mv_o,
  output logic [6:0] rise_o,
  output logic [6:0] fall_o,
  output logic quality_below_limit_o,
  output logic clean_voltage_span_low_o,
  output logic slow_rise_fault_o,
  output logic slow_fall_fault_o,
  output logic [3:0] sticky_o,
  output logic err_out_o,
  output logic [1:0] bus_status_o,
  output logic [6:0] load_o,
  output logic [6:0] load_min_o,
  output logic [6:0] load_max_o,
  output logic load_valid_o,
  output logic factory_reset_o
);
  localparam logic signed [csqm_pkg::D_W-1:0] V_MAX =
    {1'b0, {csqm_pkg::D_W-1{1'b1}}};
  localparam logic signed [csqm_pkg::D_W-1:0] V_MIN =
    {1'b1, {csqm_pkg::D_W-1{1'b0}}};

  typedef struct packed {
    csqm_pkg::csqm_mon_t mon;
    logic [15:0] div_cnt;
    logic [5:0] idx;
    logic in_frame;
    logic signed [csqm_pkg::D_W-1:0] dom_min;
    logic signed [csqm_pkg::D_W-1:0] rec_max;
    logic signed [csqm_pkg::D_W-1:0] pk_max;
    logic signed [csqm_pkg::D_W-1:0] pk_min;
    logic signed [csqm_pkg::D_W-1:0] ref_lvl;
    logic signed [csqm_pkg::D_W-1:0] prev_s;
    logic r_on;
    logic [6:0] r_cnt;
    logic f_on;
    logic [6:0] f_cnt;
    logic [6:0] rise_w;
    logic [6:0] fall_w;
    logic [6:0] rise;
    logic [6:0] fall;
    logic signed [csqm_pkg::D_W-1:0] span;
    logic signed [csqm_pkg::D_W-1:0] pp;
    logic [6:0] quality;
    logic res_vld;
    logic [3:0] live;
    logic [3:0] sticky;
    logic err_out;
    logic [31:0] sec_cnt;
    logic chg;
    logic rx_prev;
    logic [1:0] bus_stat;
    logic [23:0] busy_bits;
    logic [6:0] load;
    logic [6:0] load_min;
    logic [6:0] load_max;
    logic load_vld;
    logic [31:0] btn_cnt;
    logic btn_done;
    logic fact;
  } csqm_state_t;

  localparam csqm_state_t ST_RST = '{
    mon: csqm_pkg::CSQM_MON_IDLE, dom_min: V_MAX, rec_max: V_MIN,
    pk_max: V_MIN, pk_min: V_MAX, rx_prev: 1'b1,
    bus_stat: csqm_pkg::BUS_INVALID, load_min: csqm_pkg::PCT_MAX,
    default: '0};

  csqm_state_t st_r;
  csqm_state_t st_nxt;

  function automatic logic [6:0] csqm_clip(input logic signed [31:0] v);
    if (v < 0) begin
      return 7'h00;
    end else if (v > 32'(csqm_pkg::PCT_MAX)) begin
      return csqm_pkg::PCT_MAX;
    end
    return v[6:0];
  endfunction

  function automatic logic [6:0] csqm_sat_inc(input logic [6:0] c);
    return (c >= csqm_pkg::EDGE_SAT) ? csqm_pkg::EDGE_SAT : c + 7'h01;
  endfunction

  logic tick;
  logic measure;
  logic frame_end;
  logic signed [31:0] s_w;
  logic signed [31:0] p_w;
  logic signed [31:0] lo_w;
  logic signed [31:0] hi_w;
  logic signed [31:0] span_w;
  logic signed [31:0] pp_w;
  logic [6:0] x_w;
  logic [6:0] e_pct;
  logic [6:0] v_pct;
  logic [6:0] r_pct;
  logic [8:0] sum_w;
  logic [6:0] q_w;
  logic [3:0] flg_w;
  logic [63:0] load_w;
  logic start_p;
  logic stop_p;

  assign tick = (st_r.div_cnt == baud_div_i - 16'h0001);
  assign measure = st_r.in_frame && !arb_ack_phase_i;
  assign frame_end = st_r.in_frame && !frame_active_i;
  assign s_w = 32'(diff_mv_i);
  assign p_w = 32'(st_r.prev_s);
  assign lo_w = (32'(st_r.ref_lvl) * csqm_pkg::LO_NUM) >>> csqm_pkg::THR_SHIFT;
  assign hi_w = (32'(st_r.ref_lvl) * csqm_pkg::HI_NUM) >>> csqm_pkg::THR_SHIFT;
  assign start_p = start_stop_i && (st_r.mon == csqm_pkg::CSQM_MON_IDLE);
  assign stop_p = start_stop_i && (st_r.mon == csqm_pkg::CSQM_MON_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Quality from the accumulated frame figures
  always_comb begin
    span_w = 32'(st_r.dom_min) - 32'(st_r.rec_max);
    pp_w = 32'(st_r.pk_max) - 32'(st_r.pk_min);
    x_w = (st_r.rise_w > st_r.fall_w) ? st_r.rise_w : st_r.fall_w;
    if (x_w > csqm_pkg::EDGE_ZERO) begin
      x_w = csqm_pkg::EDGE_ZERO;
    end
    e_pct = csqm_clip((32'(csqm_pkg::EDGE_ZERO) - 32'(x_w)) * 100
                      / 32'(csqm_pkg::EDGE_ZERO));
    v_pct = csqm_clip((span_w - csqm_pkg::V_LO_MV) * 100
                      / (csqm_pkg::V_HI_MV - csqm_pkg::V_LO_MV));
    // A collapsed span would divide by zero; it scores nothing anyway
    if (span_w <= 0) begin
      r_pct = 7'h00;
    end else begin
      r_pct = csqm_clip((200 * span_w - 100 * pp_w) / span_w);
    end
    sum_w = 9'(e_pct) + 9'(v_pct) + 9'(r_pct);
    q_w = 7'(sum_w / 9'h003);
    flg_w[csqm_pkg::FLG_QUAL] = q_w < quality_limit_i;
    // Signed compare: a collapsed, negative span must still flag
    flg_w[csqm_pkg::FLG_SPAN] = span_w < $signed(32'(span_limit_mv_i));
    flg_w[csqm_pkg::FLG_RISE] = st_r.rise_w > edge_limit_i;
    flg_w[csqm_pkg::FLG_FALL] = st_r.fall_w > edge_limit_i;
    load_w = (64'(st_r.busy_bits) * 64'd100 * 64'(csqm_pkg::SMP_PER_BIT)
              * 64'(baud_div_i)) / 64'(WIN_CYC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.res_vld = 1'b0;
    st_nxt.load_vld = 1'b0;
    st_nxt.fact = 1'b0;
    st_nxt.div_cnt = tick ? 16'h0000 : st_r.div_cnt + 16'h0001;
    if (bit_start_i) begin
      st_nxt.idx = 6'h00;
      st_nxt.div_cnt = 16'h0000;
    end else if (tick) begin
      st_nxt.idx = st_r.idx + 6'h01;
    end
    st_nxt.in_frame = frame_active_i;
    if (frame_active_i && !st_r.in_frame) begin
      st_nxt.dom_min = V_MAX;
      st_nxt.rec_max = V_MIN;
      st_nxt.pk_max = V_MIN;
      st_nxt.pk_min = V_MAX;
      st_nxt.rise_w = 7'h00;
      st_nxt.fall_w = 7'h00;
      st_nxt.r_on = 1'b0;
      st_nxt.f_on = 1'b0;
    end
    if (tick) begin
      st_nxt.prev_s = diff_mv_i;
    end
    // One value per sample: a dip shorter than a sample may be missed
    if (tick && measure) begin
      if (diff_mv_i > st_r.pk_max) st_nxt.pk_max = diff_mv_i;
      if (diff_mv_i < st_r.pk_min) st_nxt.pk_min = diff_mv_i;
      if (st_r.idx >= csqm_pkg::EVAL_FIRST &&
          st_r.idx <= csqm_pkg::EVAL_LAST) begin
        if (!rx_i && diff_mv_i < st_r.dom_min) st_nxt.dom_min = diff_mv_i;
        if (rx_i && diff_mv_i > st_r.rec_max) st_nxt.rec_max = diff_mv_i;
      end
      if (st_r.idx == csqm_pkg::REF_POS && !rx_i) begin
        st_nxt.ref_lvl = diff_mv_i;
      end
      if (st_r.r_on) begin
        st_nxt.r_cnt = csqm_sat_inc(st_r.r_cnt);
        if (s_w >= hi_w) begin
          st_nxt.r_on = 1'b0;
          if (st_nxt.r_cnt > st_r.rise_w) st_nxt.rise_w = st_nxt.r_cnt;
        end else if (s_w <= lo_w) begin
          st_nxt.r_on = 1'b0;
        end
      end else if (p_w <= lo_w && s_w > lo_w) begin
        st_nxt.r_cnt = 7'h00;
        st_nxt.r_on = s_w < hi_w;
      end
      if (st_r.f_on) begin
        st_nxt.f_cnt = csqm_sat_inc(st_r.f_cnt);
        if (s_w <= lo_w) begin
          st_nxt.f_on = 1'b0;
          if (st_nxt.f_cnt > st_r.fall_w) st_nxt.fall_w = st_nxt.f_cnt;
        end else if (s_w >= hi_w) begin
          st_nxt.f_on = 1'b0;
        end
      end else if (p_w >= hi_w && s_w < hi_w) begin
        st_nxt.f_cnt = 7'h00;
        st_nxt.f_on = s_w > lo_w;
      end
    end else if (tick) begin
      // Edges cut by a suppressed phase are dropped, not timed
      st_nxt.r_on = 1'b0;
      st_nxt.f_on = 1'b0;
    end
    if (frame_end) begin
      st_nxt.rise = st_r.rise_w;
      st_nxt.fall = st_r.fall_w;
      st_nxt.span = span_w[csqm_pkg::D_W-1:0];
      st_nxt.pp = pp_w[csqm_pkg::D_W-1:0];
      st_nxt.quality = q_w;
      st_nxt.res_vld = 1'b1;
    end

    // Monitoring session and error flags
    case (st_r.mon)
      csqm_pkg::CSQM_MON_IDLE: begin
        if (start_p) begin
          st_nxt.mon = csqm_pkg::CSQM_MON_RUN;
          st_nxt.sticky = 4'h0;
          st_nxt.live = 4'h0;
        end
      end
      csqm_pkg::CSQM_MON_RUN: begin
        if (stop_p) begin
          st_nxt.mon = csqm_pkg::CSQM_MON_IDLE;
          st_nxt.live = 4'h0;
        end else if (frame_end) begin
          st_nxt.live = flg_w;
          st_nxt.sticky = st_r.sticky | flg_w;
        end
      end
      default: begin
        st_nxt.mon = csqm_pkg::CSQM_MON_IDLE;
      end
    endcase
    st_nxt.err_out = |(err_assign_i & {st_r.sticky, st_r.live});

    // Bus condition, independent of the session
    st_nxt.rx_prev = rx_i;
    if (rx_i != st_r.rx_prev) st_nxt.chg = 1'b1;
    // Last sample of a bit meets the next bit's resync pulse: count anyway
    if (tick && st_r.idx == csqm_pkg::SMP_LAST && st_r.in_frame) begin
      st_nxt.busy_bits = st_r.busy_bits + 24'h000001;
    end
    if (st_r.sec_cnt == WIN_CYC - 1) begin
      st_nxt.sec_cnt = 32'h0000_0000;
      st_nxt.chg = 1'b0;
      st_nxt.busy_bits = 24'h000000;
      if (st_r.chg || rx_i != st_r.rx_prev) begin
        st_nxt.bus_stat = csqm_pkg::BUS_ACTIVE;
      end else if (s_w < csqm_pkg::IDLE_MAX_MV) begin
        st_nxt.bus_stat = csqm_pkg::BUS_IDLE;
      end else if (s_w > csqm_pkg::FAULT_MIN_MV) begin
        st_nxt.bus_stat = csqm_pkg::BUS_FAULT;
      end else begin
        st_nxt.bus_stat = csqm_pkg::BUS_INVALID;
      end
      st_nxt.load = (load_w > 64'(csqm_pkg::PCT_MAX)) ?
                    csqm_pkg::PCT_MAX : load_w[6:0];
      if (st_nxt.load < st_r.load_min) st_nxt.load_min = st_nxt.load;
      if (st_nxt.load > st_r.load_max) st_nxt.load_max = st_nxt.load;
      st_nxt.load_vld = 1'b1;
    end else begin
      st_nxt.sec_cnt = st_r.sec_cnt + 32'h0000_0001;
    end

    // Factory default request after a long press
    if (!factory_btn_i) begin
      st_nxt.btn_cnt = 32'h0000_0000;
      st_nxt.btn_done = 1'b0;
    end else if (!st_r.btn_done) begin
      if (st_r.btn_cnt == FACT_CYC - 1) begin
        st_nxt.btn_done = 1'b1;
        st_nxt.fact = 1'b1;
        st_nxt.mon = csqm_pkg::CSQM_MON_IDLE;
        st_nxt.live = 4'h0;
        st_nxt.sticky = 4'h0;
      end else begin
        st_nxt.btn_cnt = st_r.btn_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign monitoring_o = (st_r.mon == csqm_pkg::CSQM_MON_RUN);
  assign result_valid_o = st_r.res_vld;
  assign quality_o = st_r.quality;
  assign span_mv_o = st_r.span;
  assign pp_mv_o = st_r.pp;
  assign rise_o = st_r.rise;
  assign fall_o = st_r.fall;
  assign quality_below_limit_o = st_r.live[csqm_pkg::FLG_QUAL];
  assign clean_voltage_span_low_o = st_r.live[csqm_pkg::FLG_SPAN];
  assign slow_rise_fault_o = st_r.live[csqm_pkg::FLG_RISE];
  assign slow_fall_fault_o = st_r.live[csqm_pkg::FLG_FALL];
  assign sticky_o = st_r.sticky;
  assign err_out_o = st_r.err_out;
  assign bus_status_o = st_r.bus_stat;
  assign load_o = st_r.load;
  assign load_min_o = st_r.load_min;
  assign load_max_o = st_r.load_max;
  assign load_valid_o = st_r.load_vld;
  assign factory_reset_o = st_r.fact;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_wrap;
    tick && !bit_start_i && st_r.idx == csqm_pkg::SMP_LAST
      |=> st_r.idx == 6'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("sample index did not wrap");

  property p_eval_early;
    tick && measure && st_r.idx < csqm_pkg::EVAL_FIRST && frame_active_i
      |=> $stable(st_r.dom_min) && $stable(st_r.rec_max);
  endproperty
  a_eval_early: assert property (p_eval_early) else $error("early sample used");

  property p_eval_late;
    tick && st_r.idx > csqm_pkg::EVAL_LAST && st_r.in_frame && frame_active_i
      |=> $stable(st_r.dom_min) && $stable(st_r.rec_max);
  endproperty
  a_eval_late: assert property (p_eval_late) else $error("late sample used");

  property p_suppress;
    arb_ack_phase_i && st_r.in_frame && frame_active_i
      |=> $stable(st_r.rise_w) && $stable(st_r.fall_w) && $stable(st_r.pk_max);
  endproperty
  a_suppress: assert property (p_suppress) else $error("measured while suppressed");

  property p_edge_range;
    result_valid_o |-> rise_o <= csqm_pkg::EDGE_SAT && fall_o <= csqm_pkg::EDGE_SAT;
  endproperty
  a_edge_range: assert property (p_edge_range) else $error("edge out of range");

  property p_quality;
    $rose(result_valid_o) |-> quality_o <= csqm_pkg::PCT_MAX ##1 !result_valid_o;
  endproperty
  a_quality: assert property (p_quality) else $error("quality out of range");

  property p_load_order;
    load_valid_o && $past(load_valid_o, 1) == 1'b0 |-> load_min_o <= load_max_o;
  endproperty
  a_load_order: assert property (p_load_order) else $error("load min above max");

  property p_idle;
    st_r.sec_cnt == WIN_CYC - 1 && !st_r.chg && rx_i == st_r.rx_prev
      && s_w < csqm_pkg::IDLE_MAX_MV |=> bus_status_o == csqm_pkg::BUS_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bus not reported");

  property p_sticky;
    st_r.sticky[0] && !start_p && !st_nxt.fact |=> st_r.sticky[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag lost");

  property p_err;
    ##1 err_out_o == |(($past(err_assign_i)) & $past({sticky_o, st_r.live}));
  endproperty
  a_err: assert property (p_err) else $error("error output mismatch");

  property p_fact;
    factory_reset_o |-> factory_btn_i == $past(factory_btn_i) ##1 !factory_reset_o;
  endproperty
  a_fact: assert property (p_fact) else $error("factory pulse wrong");
endmodule

// *** bench/csqm_can_bus_model.sv ***
// Behavioural CAN bus under test: frames, shaped edges, idle levels
`timescale 1ns/100ps
module csqm_can_bus_model (
  input wire logic sys_clk_i,
  output logic signed [csqm_pkg::D_W-1:0] diff_mv_o,
  output logic rx_o,
  output logic bit_start_o,
  output logic frame_active_o,
  output logic arb_ack_phase_o
);
  int rise_n;
  int idle_mv;
  logic prev_b;

  initial begin
    diff_mv_o = 13'h000;
    rx_o = 1'b1;
    bit_start_o = 1'b0;
    frame_active_o = 1'b0;
    arb_ack_phase_o = 1'b0;
    idle_mv = 0;
    prev_b = 1'b1;
    rise_n = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic set_idle(input int mv);
    @(negedge sys_clk_i);
    idle_mv = mv;
    diff_mv_o = 13'(mv);
  endtask

  // One bit, one sample per clock; rises alternate 4 and 8 samples long
  task automatic send_bit(input logic b, input logic sup, input int dom,
                          input int spk_pos, input int spk_mv);
    int k;
    int v;
    k = 4;
    if (!b && prev_b) begin
      rise_n = rise_n + 1;
      k = rise_n[0] ? 4 : 8;
    end
    for (int s = 0; s < 64; s++) begin
      @(negedge sys_clk_i);
      v = b ? 0 : dom;
      if (b != prev_b && s < k)
        v = b ? dom - dom * (s + 1) / k : dom * (s + 1) / k;
      if (s == spk_pos || s == spk_pos + 1)
        v = spk_mv;
      diff_mv_o = 13'(v);
      rx_o = b;
      bit_start_o = (s == 0);
      frame_active_o = 1'b1;
      arb_ack_phase_o = sup;
    end
    prev_b = b;
  endtask

  // Several stations may drive arbitration and acknowledge: wild levels
  task automatic send_frame(input int dom, input int ovs_mv,
                            input int dip_mv);
    prev_b = 1'b1;
    rise_n = 0;
    for (int i = 0; i < 3; i++)
      send_bit(1'b0, 1'b1, dom, 30, 4000);
    for (int i = 0; i < 19; i++)
      send_bit(i >= 2 && i % 2 == 0, 1'b0, dom,
               i == 5 ? 60 : (i == 7 ? 30 : 99),
               i == 5 ? ovs_mv : dip_mv);
    send_bit(1'b0, 1'b1, dom, 30, 4000);
    send_bit(1'b1, 1'b0, dom, 99, 0);
    @(negedge sys_clk_i);
    frame_active_o = 1'b0;
    bit_start_o = 1'b0;
    arb_ack_phase_o = 1'b0;
    diff_mv_o = 13'(idle_mv);
  endtask
endmodule

// *** bench/csqm_monitor_tb_top.sv ***
// Self-checking testbench of the CAN signal quality monitor
`timescale 1ns/100ps
module csqm_monitor_tb_top;
  localparam int FACT = 500;
  logic sys_clk_i;
  logic resetn_i;
  logic [15:0] baud_div;
  logic start_stop;
  logic factory_btn;
  logic [6:0] q_lim;
  logic [12:0] s_lim;
  logic [6:0] e_lim;
  logic [7:0] err_assign;
  wire logic signed [12:0] diff_mv;
  wire logic rx;
  wire logic bit_start;
  wire logic frame_act;
  wire logic arb_ack;
  logic monitoring_o, result_valid_o, err_out_o, load_valid_o;
  logic factory_reset_o;
  logic [6:0] quality_o, rise_o, fall_o, load_o, load_min_o, load_max_o;
  logic signed [12:0] span_mv_o, pp_mv_o;
  logic q_low, span_low, rise_slow, fall_slow;
  logic [3:0] sticky_o;
  logic [1:0] bus_status_o;
  int miscompares;
  int checks_done;

  csqm_can_bus_model bus (.sys_clk_i(sys_clk_i), .diff_mv_o(diff_mv),
    .rx_o(rx), .bit_start_o(bit_start), .frame_active_o(frame_act),
    .arb_ack_phase_o(arb_ack));

  csqm_monitor #(.WIN_CYC(640), .FACT_CYC(FACT)) dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .baud_div_i(baud_div),
    .diff_mv_i(diff_mv), .rx_i(rx), .bit_start_i(bit_start),
    .frame_active_i(frame_act), .arb_ack_phase_i(arb_ack),
    .start_stop_i(start_stop), .factory_btn_i(factory_btn),
    .quality_limit_i(q_lim), .span_limit_mv_i(s_lim),
    .edge_limit_i(e_lim), .err_assign_i(err_assign),
    .monitoring_o(monitoring_o), .result_valid_o(result_valid_o),
    .quality_o(quality_o), .span_mv_o(span_mv_o), .pp_mv_o(pp_mv_o),
    .rise_o(rise_o), .fall_o(fall_o), .quality_below_limit_o(q_low),
    .clean_voltage_span_low_o(span_low), .slow_rise_fault_o(rise_slow),
    .slow_fall_fault_o(fall_slow), .sticky_o(sticky_o),
    .err_out_o(err_out_o), .bus_status_o(bus_status_o), .load_o(load_o),
    .load_min_o(load_min_o), .load_max_o(load_max_o),
    .load_valid_o(load_valid_o), .factory_reset_o(factory_reset_o));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0d want %0d", $time, msg, got,
               exp);
    end
  endtask

  // Exact rounding of the score arithmetic is left open: allow a step
  task automatic near(input logic [6:0] got, input int exp, input string msg);
    checks_done++;
    if ((got >= exp - 1 && got <= exp + 1) !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0d", $time, msg, got);
    end
  endtask

  task automatic wait_for(input bit sel_load, input int lim);
    int n;
    n = 0;
    while ((sel_load ? load_valid_o : result_valid_o) !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check(16'(n < lim), 16'h0001, "pulse in time");
  endtask

  task automatic pulse_start();
    @(negedge sys_clk_i);
    start_stop = 1'b1;
    @(negedge sys_clk_i);
    start_stop = 1'b0;
  endtask

  task automatic check_res(input int span, input int pp, input int q,
                           input logic [3:0] live, input logic [3:0] stk);
    check(16'(span_mv_o), 16'(span), "span");
    check(16'(pp_mv_o), 16'(pp), "peak to peak");
    check(16'(rise_o), 16'h0007, "rise");
    check(16'(fall_o), 16'h0003, "fall");
    near(quality_o, q, "quality");
    check(16'({fall_slow, rise_slow, span_low, q_low}), 16'(live), "live");
    check(16'(sticky_o), 16'(stk), "sticky");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_load_status();
    fork
      bus.send_frame(2000, 2000, 2000);
      begin
        repeat (700) @(negedge sys_clk_i);
        wait_for(1'b1, 700);
        check(16'(bus_status_o), 16'(csqm_pkg::BUS_ACTIVE), "act");
        check(16'(load_o), 16'h0064, "full load");
      end
    join
    for (int i = 0; i < 3; i++) begin
      bus.set_idle(i == 0 ? 0 : (i == 1 ? 1200 : 700));
      repeat (2) begin
        @(negedge sys_clk_i);
        wait_for(1'b1, 700);
      end
      check(16'(bus_status_o), i == 0 ? 16'(csqm_pkg::BUS_IDLE) :
            (i == 1 ? 16'(csqm_pkg::BUS_FAULT) :
            16'(csqm_pkg::BUS_INVALID)), "static");
    end
    check(16'(load_o), 16'h0000, "no load");
    check(16'(load_min_o), 16'h0000, "min load");
    check(16'(load_max_o), 16'h0064, "max load");
    bus.set_idle(0);
  endtask

  task automatic t_frames();
    q_lim = 7'h46;
    s_lim = 13'h3e8;
    e_lim = 7'h05;
    err_assign = 8'h10;
    pulse_start();
    check(16'(monitoring_o), 16'h0001, "start");
    bus.send_frame(2000, 2600, 2000);
    wait_for(1'b0, 10);
    check_res(2000, 2600, 77, 4'h4, 4'h4);
    @(negedge sys_clk_i);
    check(16'(err_out_o), 16'h0000, "err out quiet");
    bus.send_frame(800, 800, 700);
    wait_for(1'b0, 10);
    check_res(700, 800, 54, 4'h7, 4'h7);
    @(negedge sys_clk_i);
    check(16'(err_out_o), 16'h0001, "err out set");
  endtask

  task automatic t_stop();
    pulse_start();
    check(16'(monitoring_o), 16'h0000, "stop");
    bus.send_frame(800, 800, 700);
    wait_for(1'b0, 10);
    check_res(700, 800, 54, 4'h0, 4'h7);
    pulse_start();
    check(16'(sticky_o), 16'h0000, "restart clears");
  endtask

  task automatic t_factory();
    int n;
    int hits;
    hits = 0;
    for (int p = 0; p < 2; p++) begin
      @(negedge sys_clk_i);
      factory_btn = 1'b1;
      n = 0;
      for (int c = 0; c < (p == 0 ? FACT - 10 : FACT + 300); c++) begin
        @(negedge sys_clk_i);
        if (factory_reset_o === 1'b1) begin
          hits++;
          n = c + 1;
        end
      end
      factory_btn = 1'b0;
      check(16'(hits), 16'(p), "factory pulses");
    end
    near(7'(n - FACT + 1), 1, "factory delay");
    check(16'(monitoring_o), 16'h0000, "factory stops");
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #5_000_000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    resetn_i = 1'b0;
    baud_div = 16'h0001;
    start_stop = 1'b0;
    factory_btn = 1'b0;
    q_lim = 7'h00;
    s_lim = 13'h000;
    e_lim = 7'h40;
    err_assign = 8'h00;
    repeat (2) @(negedge sys_clk_i);
    check(16'(load_min_o), 16'h0064, "reset min");
    check(16'(bus_status_o), 16'h0000, "reset status");
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    t_load_status();
    t_frames();
    t_stop();
    t_factory();
    summarize();
  end
endmodule
